// *** cmd_consts.svh ***
/*
  Constants for the command pointer decoder: field positions, encodings,
  reset values and the pointer step.
  Assumes it is included by its bare name from the package and the modules.
*/
`ifndef CMD_CONSTS_SVH
`define CMD_CONSTS_SVH

`define CMD_SELECT_BIT 7
`define CMD_TYPE_HI 6
`define CMD_TYPE_LO 5
`define CMD_ADDR_HI 4
`define CMD_ADDR_LO 0
`define CMD_TYPE_REPEAT 2'h0
`define CMD_TYPE_AUTOINC 2'h1
`define CMD_TYPE_RESERVED 2'h2
`define CMD_TYPE_SPECIAL 2'h3
`define CMD_SF_CLEAR_INT 5'h06
`define CMD_ADDR_RESET 5'h00
`define CMD_ADDR_STEP 5'h01

`endif

// *** cmd_field_split.sv ***
/*
  Splits a command byte into its select bit, transaction type and
  low address or special-function field.
  Assumes the byte is stable while it is decoded; purely combinational.
*/
`timescale 1ns/1ps
`include "cmd_consts.svh"

module cmd_field_split
  import cmd_pkg::*;
(
  input wire logic [7:0] byte_in, // Raw byte from the serial front end
  output logic is_cmd, // Byte carries the command select bit
  output xfer_type_t xfer_type, // Transaction type field
  output logic [4:0] low_field // Address or special-function code
);

  always_comb begin
    is_cmd = byte_in[`CMD_SELECT_BIT];
    xfer_type = xfer_type_t'(byte_in[`CMD_TYPE_HI:`CMD_TYPE_LO]);
    low_field = byte_in[`CMD_ADDR_HI:`CMD_ADDR_LO];
  end

endmodule : cmd_field_split

// *** cmd_pkg.sv ***
/*
  Types shared by the command pointer decoder.
  Assumes cmd_consts.svh is on the include path.
*/
`include "cmd_consts.svh"

package cmd_pkg;

  typedef enum logic [1:0] {
    XFER_REPEAT = `CMD_TYPE_REPEAT,
    XFER_AUTOINC = `CMD_TYPE_AUTOINC,
    XFER_RESERVED = `CMD_TYPE_RESERVED,
    XFER_SPECIAL = `CMD_TYPE_SPECIAL
  } xfer_type_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDRESSED = 3'b010,
    ST_SPECIAL = 3'b100
  } cmd_state_t;

endpackage : cmd_pkg

// *** cmd_pointer_decode.sv ***
/*
  Command byte interpreter of the serial register interface. It latches the
  register pointer and the transaction type from each repeated-byte or auto-increment command byte, steps
  the pointer on data bytes in auto-increment mode, holds it in repeated-byte
  mode, and turns the clear-interrupt special function into a one-cycle
  pulse for the interrupt logic.
  Assumes a serial front end on the same clock that flags the first written
  byte of each transfer as a command candidate and pulses data_access once
  per data byte; the register file reads reg_addr_q directly, and the
  interrupt logic clears its pending flag on int_clear_q. The interrupt flag
  itself, the register map and the bus framing live outside this block.
*/
// Functional notes
// - Auto-increment advances pointer after each data byte
// - Repeated-byte mode keeps pointer fixed
// - Special type treats low field as function
// - Repeated-byte and auto-increment types: low field selects target register
// - Clear-interrupt code clears channel interrupt
// - Type zero selects repeated-byte protocol
// - Clear-interrupt is a pulse, self-clearing
`timescale 1ns/1ps
`include "cmd_consts.svh"

module cmd_pointer_decode
  import cmd_pkg::*;
(
  input wire logic clk, // 40 MHz clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic ce, // Clock enable; low freezes all state
  input wire logic cmd_wr, // Pulse: first written byte of a transfer
  input wire logic [7:0] cmd_byte, // Byte that goes with cmd_wr
  input wire logic data_access, // Pulse: one data byte read or written
  output logic [4:0] reg_addr_q, // Register that the current data byte targets
  output logic autoinc_q, // Pointer steps after each data byte
  output logic cmd_valid_q, // A register pointer has been loaded
  output logic int_clear_q // One-cycle pulse: clear channel interrupt
);

  // Fields of the byte that came with cmd_wr
  logic is_cmd;
  xfer_type_t xfer_type;
  logic [4:0] low_field;

  // Strobes decoded in the current cycle
  logic load_ptr;
  logic load_special;
  logic fire_clear;
  logic step_ptr;

  // Registered state and its next values
  cmd_state_t state_q;
  cmd_state_t state_d;
  logic [4:0] reg_addr_d;
  logic autoinc_d;
  logic cmd_valid_d;
  logic int_clear_d;

  // Pure field slicing, no state
  cmd_field_split u_split (
    .byte_in(cmd_byte),
    .is_cmd(is_cmd),
    .xfer_type(xfer_type),
    .low_field(low_field)
  );

  // Wraps within the five-bit field: a block access past the top
  // register rolls over to register zero.
  function automatic logic [4:0] next_addr(
    input logic [4:0] addr,
    input logic inc
  );
    if (inc) begin
      next_addr = addr + `CMD_ADDR_STEP;
    end else begin
      next_addr = addr;
    end
  endfunction : next_addr

  function automatic logic is_clear_code(input logic [4:0] code);
    is_clear_code = (code == `CMD_SF_CLEAR_INT);
  endfunction : is_clear_code

  // A byte without the select bit is data, not a command. The reserved
  // type raises no strobe, so a stray one cannot corrupt the pointer.
  always_comb begin
    load_ptr = 1'b0;
    load_special = 1'b0;
    if (cmd_wr && is_cmd) begin
      case (xfer_type)
        XFER_REPEAT: begin
          load_ptr = 1'b1;
        end
        XFER_AUTOINC: begin
          load_ptr = 1'b1;
        end
        XFER_SPECIAL: begin
          load_special = 1'b1;
        end
        default: begin
          // Reserved type: no strobe at all
          load_ptr = 1'b0;
        end
      endcase
    end
  end

  // Reserved special codes fall through to nothing
  assign fire_clear = load_special && is_clear_code(low_field);

  // A data byte that shares its cycle with a command is dropped: the
  // command decides what the next data byte targets.
  assign step_ptr = data_access && !load_ptr && !load_special && (state_q != ST_IDLE);

  // ST_SPECIAL lasts one cycle after a special command; the machine then
  // returns to ST_ADDRESSED if a pointer was ever loaded, else to ST_IDLE.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (load_ptr) begin
          state_d = ST_ADDRESSED;
        end else if (load_special) begin
          state_d = ST_SPECIAL;
        end
      end
      ST_ADDRESSED: begin
        if (load_special) begin
          state_d = ST_SPECIAL;
        end
      end
      ST_SPECIAL: begin
        // Special function acts once; pointer loaded earlier stays usable
        if (load_ptr) begin
          state_d = ST_ADDRESSED;
        end else if (!load_special) begin
          state_d = cmd_valid_q ? ST_ADDRESSED : ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // The state only gates pointer stepping; the outputs carry the rest
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Pointer keeps its value across transfers until a new command byte
  always_comb begin
    reg_addr_d = reg_addr_q;
    if (load_ptr) begin
      reg_addr_d = low_field;
    end else if (step_ptr) begin
      reg_addr_d = next_addr(reg_addr_q, autoinc_q);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_addr_q <= `CMD_ADDR_RESET;
    end else if (ce) begin
      reg_addr_q <= reg_addr_d;
    end
  end

  // Repeated-byte mode is type zero; only the auto-increment type steps
  always_comb begin
    autoinc_d = autoinc_q;
    if (load_ptr) begin
      autoinc_d = (xfer_type == XFER_AUTOINC);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      autoinc_q <= 1'b0;
    end else if (ce) begin
      autoinc_q <= autoinc_d;
    end
  end

  // Once set, only reset takes the valid flag down again
  always_comb begin
    cmd_valid_d = cmd_valid_q;
    if (load_ptr) begin
      cmd_valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_valid_q <= 1'b0;
    end else if (ce) begin
      cmd_valid_q <= cmd_valid_d;
    end
  end

  // Pulse only; no sticky bit remains after the clear has acted
  always_comb begin
    int_clear_d = fire_clear;
  end

  // Held while ce is low, like every other register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_clear_q <= 1'b0;
    end else if (ce) begin
      int_clear_q <= int_clear_d;
    end
  end

endmodule : cmd_pointer_decode

// *** cmd_pointer_decode_props.sv ***
/*
  Concurrent checks and covers on the ports of cmd_pointer_decode.
  Assumes one clock domain on clk, rst asynchronous and active high; bound
  into every instance of the decoder by the statement after the module.
*/
`timescale 1ns/1ps
module cmd_pointer_decode_props (
  input wire logic clk, // Device clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic ce, // Clock enable
  input wire logic cmd_wr, // Command byte strobe
  input wire logic [7:0] cmd_byte, // Byte that goes with cmd_wr
  input wire logic data_access, // Data byte pulse
  input wire logic [4:0] reg_addr_q, // Current register pointer
  input wire logic autoinc_q, // Auto-increment mode
  input wire logic cmd_valid_q, // Pointer loaded since reset
  input wire logic int_clear_q // Clear-interrupt pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire step = ce && !cmd_wr && data_access;
  wire load = ce && cmd_wr && cmd_byte[7] && !cmd_byte[6];
  wire clr = ce && cmd_wr && cmd_byte == 8'hE6;
  property p_auto;
    step && autoinc_q |=> reg_addr_q == $past(reg_addr_q) + 5'h01;
  endproperty
  a_auto: assert property (p_auto) else $error("pointer did not step");
  property p_rep;
    step && !autoinc_q |=> $stable(reg_addr_q);
  endproperty
  a_rep: assert property (p_rep) else $error("pointer moved in byte mode");
  property p_load;
    load |=> reg_addr_q == $past(cmd_byte[4:0]) && cmd_valid_q;
  endproperty
  a_load: assert property (p_load) else $error("address not loaded");
  property p_type;
    load |=> autoinc_q == $past(cmd_byte[5]);
  endproperty
  a_type: assert property (p_type) else $error("type not loaded");
  property p_clr;
    clr |=> int_clear_q;
  endproperty
  a_clr: assert property (p_clr) else $error("clear pulse missing");
  property p_sf;
    ce && cmd_wr && cmd_byte[7:5] == 3'h7 |=> $stable(reg_addr_q);
  endproperty
  a_sf: assert property (p_sf) else $error("special command moved pointer");
  property p_pulse;
    int_clear_q |-> $past(clr) || (!$past(ce) && $past(int_clear_q));
  endproperty
  a_pulse: assert property (p_pulse) else $error("clear pulse without cause");
  property p_fall;
    int_clear_q && ce && !clr |=> !int_clear_q;
  endproperty
  a_fall: assert property (p_fall) else $error("clear pulse did not end");
  property p_hold;
    !ce || !(cmd_wr || data_access) |=> $stable(reg_addr_q) && $stable(autoinc_q);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer changed while idle");
  property p_valid;
    cmd_valid_q |=> cmd_valid_q;
  endproperty
  a_valid: assert property (p_valid) else $error("valid flag dropped");
  c_step: cover property (step && autoinc_q);
  c_load: cover property (load);
  c_clr: cover property (clr);
  c_wrap: cover property (step && autoinc_q && reg_addr_q == 5'h1F);
endmodule : cmd_pointer_decode_props
bind cmd_pointer_decode cmd_pointer_decode_props props_i (.clk, .rst, .ce, .cmd_wr, .cmd_byte,
  .data_access, .reg_addr_q, .autoinc_q, .cmd_valid_q, .int_clear_q);

// *** host_model.sv ***
/* Serial host side model: command bytes and data byte pulses. Assumes same clk. */
`timescale 1ns/1ps
module host_model (
  input wire logic clk, // Device clock
  output logic cmd_wr, // Command byte strobe
  output logic [7:0] cmd_byte, // Command byte
  output logic data_access // Data byte pulse
);
  initial begin
    cmd_wr = 1'b0;
    cmd_byte = 8'h00;
    data_access = 1'b0;
  end
  // Callers keep bit 7 set and legal codes unless a refusal is wanted
  task send(input logic [7:0] b);
    @(negedge clk);
    cmd_wr = 1'b1;
    cmd_byte = b;
    @(negedge clk);
    cmd_wr = 1'b0;
    cmd_byte = ~b; // Released byte must not look valid
  endtask : send
  task access();
    @(negedge clk);
    data_access = 1'b1;
    @(negedge clk);
    data_access = 1'b0;
  endtask : access
endmodule : host_model

// *** test_serial_command_pointer_decode.sv ***
/*
  Testbench for the command pointer decoder: command bytes and data byte
  pulses go in through the host model and the pointer outputs are compared.
  Assumes host_model, cmd_pkg and the port checker are compiled with it.
*/
`timescale 1ns/1ps
module test_serial_command_pointer_decode;
  logic clk;
  logic rst;
  logic ce;
  logic cmd_wr;
  logic data_access;
  logic autoinc_q;
  logic cmd_valid_q;
  logic int_clear_q;
  logic [7:0] cmd_byte;
  logic [4:0] reg_addr_q;
  int bad_count = 0;
  int compares = 0;
  host_model host (
    .clk(clk),
    .cmd_wr(cmd_wr),
    .cmd_byte(cmd_byte),
    .data_access(data_access)
  );
  cmd_pointer_decode dut (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .cmd_wr(cmd_wr),
    .cmd_byte(cmd_byte),
    .data_access(data_access),
    .reg_addr_q(reg_addr_q),
    .autoinc_q(autoinc_q),
    .cmd_valid_q(cmd_valid_q),
    .int_clear_q(int_clear_q)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input logic [4:0] exp, input logic [4:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  initial begin
    #(25 * 400);
    bad_count++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk(5'h00, {autoinc_q, cmd_valid_q, reg_addr_q[2:0]});
    host.send(8'hA3);
    chk(5'h03, reg_addr_q);
    chk(5'h03, {3'h0, autoinc_q, cmd_valid_q});
    host.access();
    host.access();
    chk(5'h05, reg_addr_q);
    host.send(8'hBF);
    host.access();
    chk(5'h00, reg_addr_q);
    host.send(8'h85);
    host.access();
    host.access();
    chk(5'h05, {autoinc_q, reg_addr_q[3:0]});
    host.send(8'hC7);
    host.send(8'h07);
    chk(5'h05, {autoinc_q, reg_addr_q[3:0]});
    host.send(8'hE6);
    chk(5'h15, {int_clear_q, reg_addr_q[3:0]});
    @(negedge clk);
    chk(5'h00, {4'h0, int_clear_q});
    host.send(8'hE7);
    chk(5'h00, {4'h0, int_clear_q});
    ce = 1'b0;
    host.send(8'hA1);
    ce = 1'b1;
    host.access();
    chk(5'h05, reg_addr_q);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk(5'h00, {autoinc_q, cmd_valid_q, reg_addr_q[2:0]});
    host.send(8'h82);
    chk(5'h02, reg_addr_q);
    chk(5'h01, {3'h0, autoinc_q, cmd_valid_q});
    final_report();
  end
endmodule : test_serial_command_pointer_decode
